/* File: alu_pkg.sv */
// shared constants and carriers for the byte subtract/xor/swap datapath
`default_nettype none

package alu_pkg;

    localparam int unsigned data_w = 8;
    localparam int unsigned addr_w = 7;
    localparam logic [7:0] work_rst = 8'h00;
    localparam logic flag_rst = 1'b0;
    localparam logic [6:0] addr_max = 7'h7f;
    localparam logic dest_work = 1'b0;
    localparam logic dest_file = 1'b1;

    typedef enum logic [1:0] {
        sub_work_from_file = 2'b00,
        xor_work_with_file = 2'b01,
        nibble_swap_file = 2'b10,
        xor_literal_with_work = 2'b11
    } op_t;

    // one decoded instruction from the decoder
    typedef struct packed {
        logic valid;
        op_t op;
        logic dest;
        logic [6:0] addr;
        logic [7:0] literal;
    } instr_t;

    // write back to the register file
    typedef struct packed {
        logic we;
        logic [6:0] addr;
        logic [7:0] data;
    } file_wr_t;

    typedef struct packed {
        logic carry;
        logic digit_carry_flag;
        logic zero;
    } flags_t;

endpackage

`default_nettype wire

/* File: byte_subtract_xor_swap_alu.sv */
// single-cycle byte datapath: subtract, xor with file, nibble swap, xor literal
// Functional notes
// - subtract computes file minus working, 8-bit two's complement
// - carry and digit carry are 1 unless working exceeds file value/nibble
// - destination 0 writes working register, 1 writes addressed file register, except xor literal which always writes working
// - xor with file updates only zero, result routed by destination
// - nibble swap exchanges nibbles and leaves all flags alone
// - nibble swap result goes to working or file per destination
// - xor literal writes working register, updates only zero
`timescale 1ns/1ps
`default_nettype none

module byte_subtract_xor_swap_alu (
    input wire logic clk,
    input wire logic arst_n,
    input wire alu_pkg::instr_t instr,
    output logic [6:0] file_rd_addr,
    input wire logic [7:0] file_rd_data,
    output alu_pkg::file_wr_t file_wr,
    output logic [7:0] work_q,
    output alu_pkg::flags_t flags_q
);

    ////////////////////////////////////////////////////////////////////////
    logic rst_meta_q;
    logic rst_sync_q;

    // reset takes hold at once but lets go only on a clock edge, two flops later,
    // so no register leaves reset on an edge that the async release could race
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] result;
    logic [8:0] diff;
    logic [4:0] low_diff;
    logic upd_z;
    logic upd_c;
    logic to_file;

    // read port is combinational; file value arrives in the same cycle
    // address range
    assign file_rd_addr = instr.addr;

    // inverse plus one keeps the carry out equal to no borrow, as the flag wants
    // file minus working
    assign diff = {1'b0, file_rd_data} + {1'b0, ~work_q} + 9'h001;
    assign low_diff = {1'b0, file_rd_data[3:0]} + {1'b0, ~work_q[3:0]} + 5'h01;

    always_comb
    begin
        result = 8'h00;
        upd_z = 1'b0;
        upd_c = 1'b0;
        // all four codes are legal, so no default arm
        unique case (instr.op)
            alu_pkg::sub_work_from_file:
            begin
                result = diff[7:0];
                upd_z = 1'b1;
                upd_c = 1'b1;
            end
            alu_pkg::xor_work_with_file:
            begin
                result = work_q ^ file_rd_data;
                upd_z = 1'b1;
            end
            alu_pkg::nibble_swap_file:
            begin
                result = {file_rd_data[3:0], file_rd_data[7:4]};
            end
            alu_pkg::xor_literal_with_work:
            begin
                result = work_q ^ instr.literal;
                upd_z = 1'b1;
            end
        endcase
    end

    // destination select; applies to swap too
    assign to_file = instr.valid && instr.dest == alu_pkg::dest_file
                     && instr.op != alu_pkg::xor_literal_with_work;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
            work_q <= alu_pkg::work_rst;
        else if (instr.valid && !to_file)
            work_q <= result;
    end

    always_ff @(posedge clk or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
            file_wr <= '0;
        else
        begin
            // write-back lands one edge after the op; a read of the same byte in the
            // very next cycle sees the old value unless the file forwards it
            file_wr.we <= to_file;
            file_wr.addr <= instr.addr;
            file_wr.data <= result;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
            flags_q <= '{carry: alu_pkg::flag_rst, digit_carry_flag: alu_pkg::flag_rst,
                         zero: alu_pkg::flag_rst};
        else if (instr.valid)
        begin
            if (upd_z)
                flags_q.zero <= (result == 8'h00);
            // carry and digit carry move only on a subtract
            // borrow is inverted carry
            if (upd_c)
            begin
                flags_q.carry <= diff[8];
                flags_q.digit_carry_flag <= low_diff[4];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    chk_sub_result: assert property (@(posedge clk) disable iff (!rst_sync_q)
        instr.valid && instr.op == alu_pkg::sub_work_from_file && !to_file
        |=> work_q == 8'($past(file_rd_data) - $past(work_q)))
        else $error("subtract result wrong");
    chk_sub_carry: assert property (@(posedge clk) disable iff (!rst_sync_q)
        instr.valid && instr.op == alu_pkg::sub_work_from_file
        |=> flags_q.carry == ($past(work_q) <= $past(file_rd_data))
            && flags_q.digit_carry_flag == ($past(work_q[3:0]) <= $past(file_rd_data[3:0])))
        else $error("subtract carry wrong");
    chk_dest_file: assert property (@(posedge clk) disable iff (!rst_sync_q)
        instr.valid && instr.dest && instr.op != alu_pkg::xor_literal_with_work
        |=> file_wr.we && $stable(work_q) && file_wr.addr == $past(instr.addr))
        else $error("file destination not honoured");
    chk_xor_flags: assert property (@(posedge clk) disable iff (!rst_sync_q)
        instr.valid && instr.op == alu_pkg::xor_work_with_file
        |=> $stable(flags_q.carry) && $stable(flags_q.digit_carry_flag))
        else $error("xor touched carry");
    chk_swap_flags: assert property (@(posedge clk) disable iff (!rst_sync_q)
        instr.valid && instr.op == alu_pkg::nibble_swap_file |=> $stable(flags_q))
        else $error("swap changed flags");
    chk_swap_data: assert property (@(posedge clk) disable iff (!rst_sync_q)
        instr.valid && instr.op == alu_pkg::nibble_swap_file && !instr.dest
        |=> work_q == {$past(file_rd_data[3:0]), $past(file_rd_data[7:4])})
        else $error("swap to working wrong");
    chk_xorlit_work: assert property (@(posedge clk) disable iff (!rst_sync_q)
        instr.valid && instr.op == alu_pkg::xor_literal_with_work
        |=> work_q == ($past(work_q) ^ $past(instr.literal)) && !file_wr.we)
        else $error("literal xor wrong");
    chk_zero_flag: assert property (@(posedge clk) disable iff (!rst_sync_q)
        instr.valid && upd_z |=> flags_q.zero == ($past(result) == 8'h00))
        else $error("zero flag wrong");

    // checks below lean only on the operands, never on the internal result
    chk_sub_file: assert property (@(posedge clk) disable iff (!rst_sync_q)
        instr.valid && instr.op == alu_pkg::sub_work_from_file && instr.dest
        |=> file_wr.data == 8'($past(file_rd_data) - $past(work_q)))
        else $error("subtract write-back wrong");
    chk_sub_zero: assert property (@(posedge clk) disable iff (!rst_sync_q)
        instr.valid && instr.op == alu_pkg::sub_work_from_file
        |=> flags_q.zero == ($past(file_rd_data) == $past(work_q)))
        else $error("subtract zero wrong");
    chk_dest_work: assert property (@(posedge clk) disable iff (!rst_sync_q)
        instr.valid && instr.dest == alu_pkg::dest_work
        |=> !file_wr.we)
        else $error("working destination wrote the file");
    chk_xor_work: assert property (@(posedge clk) disable iff (!rst_sync_q)
        instr.valid && instr.op == alu_pkg::xor_work_with_file && !instr.dest
        |=> work_q == ($past(work_q) ^ $past(file_rd_data)))
        else $error("xor to working wrong");
    chk_xor_file: assert property (@(posedge clk) disable iff (!rst_sync_q)
        instr.valid && instr.op == alu_pkg::xor_work_with_file && instr.dest
        |=> file_wr.data == ($past(work_q) ^ $past(file_rd_data)) && $stable(work_q))
        else $error("xor to file wrong");
    chk_swap_file: assert property (@(posedge clk) disable iff (!rst_sync_q)
        instr.valid && instr.op == alu_pkg::nibble_swap_file && instr.dest
        |=> file_wr.data == {$past(file_rd_data[3:0]), $past(file_rd_data[7:4])})
        else $error("swap to file wrong");
    chk_xorlit_flags: assert property (@(posedge clk) disable iff (!rst_sync_q)
        instr.valid && instr.op == alu_pkg::xor_literal_with_work
        |=> $stable(flags_q.carry) && $stable(flags_q.digit_carry_flag))
        else $error("literal xor touched carry");

    // a bubble must raise no file write and leave working and flags alone
    chk_idle_quiet: assert property (@(posedge clk) disable iff (!rst_sync_q)
        !instr.valid |=> !file_wr.we && $stable(work_q) && $stable(flags_q))
        else $error("idle cycle changed state");

    cov_sub_borrow: cover property (@(posedge clk) disable iff (!rst_sync_q)
        instr.valid && instr.op == alu_pkg::sub_work_from_file ##1 !flags_q.carry);
    cov_xor_zero: cover property (@(posedge clk) disable iff (!rst_sync_q)
        instr.valid && instr.op == alu_pkg::xor_work_with_file ##1 flags_q.zero);
    cov_swap_file: cover property (@(posedge clk) disable iff (!rst_sync_q)
        instr.valid && instr.op == alu_pkg::nibble_swap_file && instr.dest);
    cov_sub_half_borrow: cover property (@(posedge clk) disable iff (!rst_sync_q)
        instr.valid && instr.op == alu_pkg::sub_work_from_file ##1 !flags_q.digit_carry_flag);
    // literal xor with the destination bit set must still land in working
    cov_lit_dest_set: cover property (@(posedge clk) disable iff (!rst_sync_q)
        instr.valid && instr.op == alu_pkg::xor_literal_with_work && instr.dest);

endmodule

`default_nettype wire

/* File: byte_subtract_xor_swap_alu_tb.sv */
// self-checking bench for the byte subtract/xor/swap datapath
`timescale 1ns/1ps
`default_nettype none

module byte_subtract_xor_swap_alu_tb;
    logic clk;
    logic arst_n;
    alu_pkg::instr_t instr;
    logic [6:0] file_rd_addr;
    logic [7:0] file_rd_data;
    alu_pkg::file_wr_t file_wr;
    logic [7:0] work_q;
    alu_pkg::flags_t flags_q;
    logic [7:0] exp_w;
    alu_pkg::flags_t exp_fl;
    int err_total;
    int n_tests;

    byte_subtract_xor_swap_alu i_byte_subtract_xor_swap_alu (
        .clk(clk), .arst_n(arst_n), .instr(instr), .file_rd_addr(file_rd_addr),
        .file_rd_data(file_rd_data), .file_wr(file_wr), .work_q(work_q), .flags_q(flags_q));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_tests++;
        if (seen !== want)
        begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic end_sim;
        if (err_total == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // also used mid-run, so the model state is cleared here too
    task automatic do_reset;
        @(negedge clk);
        arst_n <= 1'b0;
        repeat (10) @(negedge clk);
        check({work_q, flags_q, file_wr.we}, 12'h000);
        arst_n <= 1'b1;
        exp_w = alu_pkg::work_rst;
        exp_fl = '0;
        repeat (3) @(negedge clk);
    endtask

    task automatic run_op(input alu_pkg::op_t op, input logic dest, input logic [6:0] a,
                          input logic [7:0] k, input logic [7:0] f);
        logic [7:0] r;
        logic to_w;
        @(negedge clk);
        instr <= '{1'b1, op, dest, a, k};
        file_rd_data <= f;
        to_w = (op == alu_pkg::xor_literal_with_work) || !dest;
        case (op)
            alu_pkg::sub_work_from_file:
            begin
                r = f - exp_w;
                exp_fl.carry = (exp_w <= f);
                exp_fl.digit_carry_flag = (exp_w[3:0] <= f[3:0]);
            end
            alu_pkg::xor_work_with_file: r = exp_w ^ f;
            alu_pkg::nibble_swap_file: r = {f[3:0], f[7:4]};
            default: r = exp_w ^ k;
        endcase
        if (op != alu_pkg::nibble_swap_file)
            exp_fl.zero = (r == 8'h00);
        if (to_w)
            exp_w = r;
        #1;
        check(file_rd_addr, a);
        @(posedge clk);
        #1;
        check(work_q, exp_w);
        check(flags_q, exp_fl);
        check(file_wr.we, !to_w);
        if (!to_w)
            check({file_wr.addr, file_wr.data}, {a, r});
    endtask

    task automatic idle;
        @(negedge clk);
        instr.valid <= 1'b0;
        @(posedge clk);
        #1;
        check({file_wr.we, work_q, flags_q}, {1'b0, exp_w, exp_fl});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_sub;
        run_op(alu_pkg::xor_literal_with_work, 1'b0, 7'h00, 8'h20, 8'h00);
        run_op(alu_pkg::sub_work_from_file, 1'b1, 7'h11, 8'h00, 8'h10);
        run_op(alu_pkg::sub_work_from_file, 1'b0, 7'h12, 8'h00, 8'h20);
        run_op(alu_pkg::xor_literal_with_work, 1'b0, 7'h00, 8'h08, 8'h00);
        run_op(alu_pkg::sub_work_from_file, 1'b0, 7'h13, 8'h00, 8'h17);
        idle;
    endtask

    task automatic t_xor;
        run_op(alu_pkg::xor_work_with_file, 1'b1, 7'h7f, 8'h00, 8'h0f);
        run_op(alu_pkg::xor_work_with_file, 1'b0, 7'h21, 8'h00, 8'h5a);
        run_op(alu_pkg::xor_literal_with_work, 1'b1, 7'h7f, 8'hff, 8'h00);
        run_op(alu_pkg::xor_literal_with_work, 1'b1, 7'h05, exp_w, 8'h00);
        idle;
    endtask

    task automatic t_swap;
        run_op(alu_pkg::nibble_swap_file, 1'b0, 7'h30, 8'h00, 8'ha5);
        run_op(alu_pkg::nibble_swap_file, 1'b1, 7'h00, 8'h00, 8'h3c);
        idle;
    endtask

    initial
    begin
        arst_n = 1'b0;
        instr = '0;
        file_rd_data = 8'h00;
        err_total = 0;
        n_tests = 0;
        do_reset;
        t_sub;
        t_xor;
        t_swap;
        do_reset;
        t_swap;
        end_sim;
    end

    // the run needs well under 100 cycles
    initial
    begin
        #20000;
        err_total++;
        end_sim;
    end
endmodule

`default_nettype wire
